// File: src/otm_defs.svh
`ifndef OTM_DEFS_SVH
`define OTM_DEFS_SVH
// Behaviour
// [R1] suspend change interrupt gated by enable bit 6
// [R2] remote connect change gated by bit 5
// [R3] B-device session valid change gated by bit 4
// [R4] A-device session valid change gated by bit 3
// [R5] B-device session end change gated by bit 2
// [R6] A-device bus voltage change gated by bit 1
// [R7] plug ident change gated by bit 0
// [R8] one-shot timer read 6A, written EA
// [R9] start bit one loads value, starts counting
// [R10] start bit zero halts one-shot timer
// [R11] expiry clears one-shot start bit by itself
// [R12] 24-bit load value, 0.01 ms per count
// [R13] stopwatch read 6C, written EC
// [R14] stopwatch start counts upward from zero
// [R15] stopwatch stops and clears at all ones; the code stops it and holds the count at all ones
// [R16] stopwatch start bit zero stops counting
// [R17] enabled flag stops stopwatch, freezes time
// [R18] stopwatch read returns current time 23:0
// [R19] bits 30:24 reserved, fields reset zero
// [R20] one-shot expiry interrupt gated by bit 10
// [R21] flags set on change, write one clears
// [R22] interrupt while any flag and enable set
// [R23] 0.01 ms tick; expiry after programmed ticks

// ************************************************************
// command codes
// ************************************************************
`define OTM_CMD_FLAGS_RD 8'h68
`define OTM_CMD_FLAGS_WR 8'hE8
`define OTM_CMD_IRQEN_RD 8'h69
`define OTM_CMD_IRQEN_WR 8'hE9
`define OTM_CMD_ONESHOT_RD 8'h6A
`define OTM_CMD_ONESHOT_WR 8'hEA
`define OTM_CMD_STOPWATCH_RD 8'h6C
`define OTM_CMD_STOPWATCH_WR 8'hEC

// ************************************************************
// fields and reset values
// ************************************************************
`define OTM_RUN_BIT 31
`define OTM_VALUE_W 24
`define OTM_RSVD_W 7
`define OTM_STATUS_W 7
`define OTM_TIMER_FLAG_BIT 10
`define OTM_EVENT_MASK 16'h047F
`define OTM_REG_RESET 32'h0000_0000
`define OTM_IRQ_RESET 16'h0000

// ************************************************************
// timing
// ************************************************************
`define OTM_CLK_PERIOD_NS 40
`define OTM_TICK_PERIOD_NS 10000
`define OTM_TICK_CYCLES (`OTM_TICK_PERIOD_NS / `OTM_CLK_PERIOD_NS)
`define OTM_TICK_CNT_W 8
`endif

// File: src/otm_pkg.sv
package otm_pkg;
   typedef logic [7:0] otm_cmd_type;
   typedef logic [15:0] otm_irq_vec_type;
   typedef logic [31:0] otm_word_type;
endpackage

// File: src/otm_timers.sv
`timescale 1ns/10ps
`include "otm_defs.svh"

module otm_timers
   import otm_pkg::*;
#(
   parameter int COUNT_W = `OTM_VALUE_W
) (
   input wire logic clk, // 25 MHz system clock
   input wire logic rstn, // asynchronous reset, active low
   input wire logic cmd_valid, // one-cycle command strobe
   input wire otm_cmd_type cmd_code, // command code, bit 7 set for writes
   input wire otm_word_type cmd_wdata, // write data for write codes
   output otm_word_type rd_data, // read answer, held until next read
   output logic rd_valid, // one-cycle pulse with read answer
   input wire logic suspend_status, // bus suspend state
   input wire logic remote_connect_status, // remote connection state
   input wire logic bdev_session_valid, // B-device session valid
   input wire logic adev_session_valid, // A-device session valid
   input wire logic bdev_session_end, // B-device session end
   input wire logic adev_bus_voltage_valid, // A-device bus voltage valid
   input wire logic plug_ident_status, // plug identification
   output logic otg_irq // interrupt request, active high
);

   // ************************************************************
   // elaboration checks
   // ************************************************************
   if (COUNT_W < 2 || COUNT_W > `OTM_VALUE_W) begin : g_bad_width
      $error("otm_timers: COUNT_W must lie in 2..24");
   end

   localparam logic [`OTM_TICK_CNT_W-1:0] TICK_LAST =
      `OTM_TICK_CNT_W'(`OTM_TICK_CYCLES - 1);
   localparam logic [COUNT_W-1:0] COUNT_ONE = COUNT_W'(1);
   localparam logic [COUNT_W-1:0] COUNT_ALL = {COUNT_W{1'b1}};
   localparam logic [`OTM_RSVD_W-1:0] RSVD_ZERO = `OTM_RSVD_W'(0);

   // ************************************************************
   // command decode
   // ************************************************************
   logic wr_flags;
   logic wr_irq_en;
   logic wr_oneshot;
   logic wr_stopwatch;
   logic rd_cmd;
   logic wr_run;

   assign wr_flags = cmd_valid && (cmd_code == `OTM_CMD_FLAGS_WR);
   assign wr_irq_en = cmd_valid && (cmd_code == `OTM_CMD_IRQEN_WR);
   assign wr_oneshot = cmd_valid && (cmd_code == `OTM_CMD_ONESHOT_WR); // R8
   assign wr_stopwatch = cmd_valid && (cmd_code == `OTM_CMD_STOPWATCH_WR); // R13
   assign rd_cmd = cmd_valid && !cmd_code[7];
   assign wr_run = cmd_wdata[`OTM_RUN_BIT];

   // ************************************************************
   // registers
   // ************************************************************
   otm_irq_vec_type irq_en;
   otm_irq_vec_type flags;
   logic [`OTM_STATUS_W-1:0] status_prev;
   logic primed;
   logic [`OTM_TICK_CNT_W-1:0] tick_cnt;
   logic tick;
   logic os_run;
   logic [COUNT_W-1:0] os_load;
   logic [COUNT_W-1:0] os_count;
   logic os_expire;
   logic sw_run;
   logic [COUNT_W-1:0] sw_count;
   logic pending;

   // ************************************************************
   // tick prescaler
   // ************************************************************
   // free running, so the first tick after a start lands 1..250 cycles later
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else if (tick_cnt == TICK_LAST) begin
         tick_cnt <= '0;
         tick <= 1'b1; // R23
      end else begin
         tick_cnt <= tick_cnt + `OTM_TICK_CNT_W'(1);
         tick <= 1'b0;
      end
   end

   // ************************************************************
   // interrupt enables
   // ************************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_en <= `OTM_IRQ_RESET;
      end else if (wr_irq_en) begin
         irq_en <= cmd_wdata[15:0] & `OTM_EVENT_MASK;
      end
   end

   // ************************************************************
   // status change detection and event flags
   // ************************************************************
   logic [`OTM_STATUS_W-1:0] status_now;
   logic [`OTM_STATUS_W-1:0] status_change;
   otm_irq_vec_type flag_set;
   otm_irq_vec_type flag_clr;
   otm_irq_vec_type next_flags;

   assign status_now = {suspend_status, remote_connect_status, bdev_session_valid,
                        adev_session_valid, bdev_session_end, adev_bus_voltage_valid,
                        plug_ident_status};

   // skip the first cycle after reset so a high status is no false change
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_prev <= '0;
         primed <= 1'b0;
      end else begin
         status_prev <= status_now;
         primed <= 1'b1;
      end
   end

   always_comb begin
      flag_set = '0;
      flag_set[`OTM_STATUS_W-1:0] = primed ? (status_now ^ status_prev) : '0;
      flag_set[`OTM_TIMER_FLAG_BIT] = os_expire;
      flag_clr = wr_flags ? cmd_wdata[15:0] : '0;
      // a set in the clearing cycle wins
      next_flags = ((flags & ~flag_clr) | flag_set) & `OTM_EVENT_MASK; // R21
   end

   assign status_change = flag_set[`OTM_STATUS_W-1:0];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags <= `OTM_IRQ_RESET;
      end else begin
         flags <= next_flags;
      end
   end

   // enables gate each flag, bits 6..0 and the timer bit 10
   assign pending = |(flags & irq_en); // R1 R2 R3 R4 R5 R6 R7 R20 R22

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         otg_irq <= 1'b0;
      end else begin
         otg_irq <= pending; // R22
      end
   end

   // ************************************************************
   // one-shot timer
   // ************************************************************
   // values 0 and 1 both expire on the first tick
   assign os_expire = os_run && tick && !wr_oneshot && (os_count <= COUNT_ONE); // R23

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         os_run <= 1'b0;
         os_load <= '0; // R19
         os_count <= '0;
      end else if (wr_oneshot) begin
         os_load <= cmd_wdata[COUNT_W-1:0]; // R12
         os_run <= wr_run; // R10
         if (wr_run) begin
            os_count <= cmd_wdata[COUNT_W-1:0]; // R9
         end
      end else if (os_expire) begin
         os_run <= 1'b0; // R11
         os_count <= '0;
      end else if (os_run && tick) begin
         os_count <= os_count - COUNT_ONE;
      end
   end

   // ************************************************************
   // stopwatch
   // ************************************************************
   // an enabled flag freezes the count, which then is the current time
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sw_run <= 1'b0;
         sw_count <= '0; // R19
      end else if (wr_stopwatch) begin
         sw_run <= wr_run; // R16
         if (wr_run) begin
            sw_count <= '0; // R14
         end
      end else if (sw_run && pending) begin
         sw_run <= 1'b0; // R17
      end else if (sw_run && sw_count == COUNT_ALL) begin
         sw_run <= 1'b0; // R15
      end else if (sw_run && tick) begin
         sw_count <= sw_count + COUNT_ONE;
      end
   end

   // ************************************************************
   // read answers
   // ************************************************************
   otm_word_type next_rd_data;

   always_comb begin
      unique case (cmd_code)
         `OTM_CMD_FLAGS_RD: next_rd_data = {16'h0000, flags};
         `OTM_CMD_IRQEN_RD: next_rd_data = {16'h0000, irq_en};
         `OTM_CMD_ONESHOT_RD: begin
            next_rd_data = {os_run, RSVD_ZERO, `OTM_VALUE_W'(os_load)}; // R8 R19
         end
         `OTM_CMD_STOPWATCH_RD: begin
            next_rd_data = {sw_run, RSVD_ZERO, `OTM_VALUE_W'(sw_count)}; // R13 R18
         end
         default: next_rd_data = `OTM_REG_RESET;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_data <= `OTM_REG_RESET;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_cmd;
         if (rd_cmd) begin
            rd_data <= next_rd_data;
         end
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   a_irq_gate: assert property ( // R1 R2 R3 R4 R5 R6 R7 R20 R22
      @(posedge clk) disable iff (!rstn)
      otg_irq == |($past(flags) & $past(irq_en)))
      else $error("interrupt does not follow enabled flags");

   a_os_start: assert property ( // R9
      @(posedge clk) disable iff (!rstn)
      (wr_oneshot && wr_run) |=> os_run && os_count == $past(cmd_wdata[COUNT_W-1:0]))
      else $error("one-shot did not load and start");

   a_os_stop: assert property ( // R10
      @(posedge clk) disable iff (!rstn)
      (wr_oneshot && !wr_run) |=> !os_run)
      else $error("one-shot did not halt");

   a_os_expiry: assert property ( // R11
      @(posedge clk) disable iff (!rstn)
      (os_run && tick && !wr_oneshot && os_count <= COUNT_ONE)
         |=> !os_run && flags[`OTM_TIMER_FLAG_BIT])
      else $error("one-shot expiry not handled");

   a_os_countdown: assert property ( // R23
      @(posedge clk) disable iff (!rstn)
      (os_run && tick && !wr_oneshot && os_count > COUNT_ONE)
         |=> os_run && os_count == $past(os_count) - COUNT_ONE)
      else $error("one-shot did not count down on tick");

   a_tick_space: assert property ( // R23
      @(posedge clk) disable iff (!rstn)
      tick |=> !tick [*8])
      else $error("ticks too close together");

   a_sw_start: assert property ( // R14
      @(posedge clk) disable iff (!rstn)
      (wr_stopwatch && wr_run) |=> sw_run && sw_count == '0)
      else $error("stopwatch did not start from zero");

   a_sw_full: assert property ( // R15
      @(posedge clk) disable iff (!rstn)
      (sw_run && sw_count == COUNT_ALL && !wr_stopwatch) |=> !sw_run)
      else $error("stopwatch ran past all ones");

   a_sw_stop: assert property ( // R16
      @(posedge clk) disable iff (!rstn)
      (wr_stopwatch && !wr_run) |=> !sw_run && $stable(sw_count))
      else $error("stopwatch did not stop");

   a_sw_freeze: assert property ( // R17
      @(posedge clk) disable iff (!rstn)
      (sw_run && pending && !wr_stopwatch) |=> !sw_run && $stable(sw_count))
      else $error("enabled event did not freeze stopwatch");

   a_flag_hold: assert property ( // R21
      @(posedge clk) disable iff (!rstn)
      !wr_flags |=> (flags & $past(flags)) == $past(flags))
      else $error("flag fell without a clearing write");

   a_rd_time: assert property ( // R18 R19
      @(posedge clk) disable iff (!rstn)
      (cmd_valid && cmd_code == `OTM_CMD_STOPWATCH_RD)
         |=> rd_valid && rd_data[COUNT_W-1:0] == $past(sw_count)
             && rd_data[30:24] == RSVD_ZERO)
      else $error("stopwatch read returned wrong time");

   a_change_flag: assert property ( // R21
      @(posedge clk) disable iff (!rstn)
      (|status_change)
         |=> (flags[`OTM_STATUS_W-1:0] & $past(status_change)) == $past(status_change))
      else $error("status change did not raise its flag");

   a_flag_clear: assert property ( // R21
      @(posedge clk) disable iff (!rstn)
      (wr_flags && (flag_set & cmd_wdata[15:0]) == '0)
         |=> (flags & $past(cmd_wdata[15:0])) == '0)
      else $error("written one did not clear its flag");

   a_en_write: assert property ( // R1 R2 R3 R4 R5 R6 R7 R20
      @(posedge clk) disable iff (!rstn)
      wr_irq_en |=> irq_en == ($past(cmd_wdata[15:0]) & `OTM_EVENT_MASK))
      else $error("enable write not stored");

   a_rd_pulse: assert property ( // R8 R13
      @(posedge clk) disable iff (!rstn)
      rd_valid == $past(rd_cmd))
      else $error("read answer pulse misplaced");

   a_os_read: assert property ( // R8 R19
      @(posedge clk) disable iff (!rstn)
      (cmd_valid && cmd_code == `OTM_CMD_ONESHOT_RD)
         |=> rd_data[`OTM_RUN_BIT] == $past(os_run) && rd_data[30:24] == RSVD_ZERO
             && rd_data[COUNT_W-1:0] == $past(os_load))
      else $error("one-shot read returned wrong word");

   a_os_idle: assert property ( // R10
      @(posedge clk) disable iff (!rstn)
      (!os_run && !wr_oneshot) |=> !os_run)
      else $error("halted one-shot restarted by itself");

   a_sw_idle: assert property ( // R16
      @(posedge clk) disable iff (!rstn)
      (!sw_run && !wr_stopwatch) |=> !sw_run && $stable(sw_count))
      else $error("stopped stopwatch moved");

   a_sw_count: assert property ( // R14
      @(posedge clk) disable iff (!rstn)
      (sw_run && tick && !pending && !wr_stopwatch && sw_count != COUNT_ALL)
         |=> sw_run && sw_count == $past(sw_count) + COUNT_ONE)
      else $error("stopwatch did not count up on tick");

   a_tick_period: assert property ( // R23
      @(posedge clk) disable iff (!rstn)
      (tick_cnt == TICK_LAST) |=> tick && tick_cnt == '0)
      else $error("tick not raised at end of period");

endmodule // otm_timers

// File: dv/otm_host_model.sv
`timescale 1ns/10ps
module otm_host_model
   import otm_pkg::*;
(
   input wire logic clk, // system clock
   output logic cmd_valid, // command strobe
   output otm_cmd_type cmd_code, // command code
   output otm_word_type cmd_wdata, // write data
   input wire otm_word_type rd_data, // read answer
   input wire logic rd_valid, // read answer strobe
   output logic [6:0] st // status levels, suspend down to plug ident
);
   otm_word_type last_rd;
   logic last_ok;
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 32'h0000_0000;
      st = 7'h00;
   end
   // ************************************************************
   // one command; held until the edge that takes it
   // ************************************************************
   task automatic cmd(input otm_cmd_type code, input otm_word_type data);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_code <= code;
      cmd_wdata <= data;
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1;
      last_ok = rd_valid;
      last_rd = rd_data;
   endtask
   task automatic flip(input int i);
      @(posedge clk);
      st[i] <= ~st[i];
   endtask
endmodule // otm_host_model

// File: dv/testbench.sv
`timescale 1ns/10ps
module testbench;
   import otm_pkg::*;
   localparam int CW = 4;
   localparam int TICK = 250;
   localparam int LIMIT = 30000;
   localparam otm_word_type RUN = 32'h8000_0000;
   logic clk, rstn, cmd_valid, rd_valid, otg_irq;
   otm_cmd_type cmd_code;
   otm_word_type cmd_wdata, rd_data, v, w;
   logic [6:0] st;
   int n_fail, n_tests, cyc, t0, n;
   initial clk = 1'b0;
   always #20 clk = ~clk;
   otm_timers #(.COUNT_W(CW)) dut_u (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
      .suspend_status(st[6]), .remote_connect_status(st[5]), .bdev_session_valid(st[4]),
      .adev_session_valid(st[3]), .bdev_session_end(st[2]),
      .adev_bus_voltage_valid(st[1]), .plug_ident_status(st[0]), .otg_irq(otg_irq));
   otm_host_model host_u (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid), .st(st));
   // ************************************************************
   // helpers
   // ************************************************************
   function automatic otm_word_type en_exp(input otm_word_type x);
      return {16'h0000, x[15:0] & 16'h047F};
   endfunction
   task automatic check(input otm_word_type got, input otm_word_type exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input otm_cmd_type c, input otm_word_type d);
      host_u.cmd(c, d);
   endtask
   task automatic rd(input otm_cmd_type c);
      host_u.cmd(c, 32'h0000_0000);
      w = host_u.last_rd;
      check({31'h0, host_u.last_ok}, 32'h1);
   endtask
   task automatic irq_is(input logic e);
      repeat (3) @(posedge clk);
      #1;
      check({31'h0, otg_irq}, {31'h0, e});
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_fail++;
         final_report();
      end
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      rstn = 1'b0;
      v = $urandom(32'hBBF6);
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      rd(8'h6A);
      check(w, 32'h0);
      rd(8'h6C);
      check(w, 32'h0);
      v = $urandom;
      wr(8'hE9, v);
      rd(8'h69);
      check(w, en_exp(v));
      for (int i = 0; i < 7; i++) begin
         wr(8'hE8, 32'hFFFF);
         wr(8'hE9, 32'h047F ^ (1 << i));
         host_u.flip(i);
         irq_is(1'b0);
         rd(8'h68);
         check(w, 1 << i);
         wr(8'hE8, 32'h0);
         wr(8'hE9, 32'h047F);
         irq_is(1'b1);
         wr(8'hE8, 1 << i);
         irq_is(1'b0);
      end
      // reserved bits written high must read back low
      n = $urandom_range(15, 2);
      wr(8'hEA, 32'hFF00_0000 | n);
      t0 = cyc;
      rd(8'h6A);
      check(w, RUN | n);
      while (otg_irq !== 1'b1 && cyc - t0 < (n + 1) * TICK + 10) begin
         @(posedge clk);
         #1;
      end
      check(32'(cyc - t0 > (n - 1) * TICK && cyc - t0 <= n * TICK + 4), 32'h1);
      rd(8'h6A);
      check(w, n);
      rd(8'h68);
      check(w, 32'h400);
      wr(8'hE9, 32'h007F);
      irq_is(1'b0);
      wr(8'hE8, 32'hFFFF);
      wr(8'hEA, RUN | 2);
      wr(8'hEA, 32'h1);
      repeat (3 * TICK) @(posedge clk);
      rd(8'h68);
      check(w, 32'h0);
      // stopwatch runs, stops, restarts from zero, saturates
      wr(8'hE9, 32'h0);
      wr(8'hEC, RUN);
      repeat (3 * TICK) @(posedge clk);
      rd(8'h6C);
      check(32'(w inside {RUN | 3, RUN | 4}), 32'h1);
      wr(8'hEC, 32'h0);
      rd(8'h6C);
      v = w;
      repeat (2 * TICK) @(posedge clk);
      rd(8'h6C);
      check(w, v);
      check({31'h0, v[31]}, 32'h0);
      wr(8'hEC, RUN);
      rd(8'h6C);
      check(32'(w inside {RUN, RUN | 1}), 32'h1);
      repeat (17 * TICK) @(posedge clk);
      rd(8'h6C);
      check(w, 32'((1 << CW) - 1));
      // enabled event freezes the stopwatch
      wr(8'hE8, 32'hFFFF);
      wr(8'hE9, 32'h1);
      wr(8'hEC, RUN);
      repeat (2 * TICK) @(posedge clk);
      host_u.flip(0);
      repeat (3) @(posedge clk);
      rd(8'h6C);
      v = w;
      check({31'h0, v[31]}, 32'h0);
      check(32'(v inside {32'h2, 32'h3}), 32'h1);
      repeat (TICK + 5) @(posedge clk);
      rd(8'h6C);
      check(w, v);
      final_report();
   end
endmodule // testbench
